/* spims_map.vh */
// Purpose: constants for the serial master/slave port
// Assumes: 125 MHz system clock
// Notes:   control bits are plain ports, positions kept for software mapping
`ifndef SPIMS_MAP_VH
`define SPIMS_MAP_VH
// status/control field positions
`define SPIMS_BIT_ORDER_POS    7
`define SPIMS_DELAY_HI_POS     6
`define SPIMS_DELAY_LO_POS     5
`define SPIMS_READ_FULL_POS    0
// port control field positions
`define SPIMS_EDGE_POS         7
`define SPIMS_IRQ_EN_POS       6
`define SPIMS_START_POS        4
`define SPIMS_IDLE_STATE_POS   3
// timing
`define SPIMS_CLK_MHZ          125
`define SPIMS_MAX_BIT_MHZ      8
// least half period so the bit rate stays at or under the top rate
`define SPIMS_MIN_HALF_CYC     ((`SPIMS_CLK_MHZ + 2*`SPIMS_MAX_BIT_MHZ - 1) / (2*`SPIMS_MAX_BIT_MHZ))
`define SPIMS_BITS             8
`define SPIMS_RESET_BYTE       8'h00
`endif

/* spims_sync.v */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module spims_sync #(
   parameter W = 3
) (
   input  wire         clock,
   input  wire         nrst,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_reg;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= {W{1'b0}};
         q        <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* spims_port.v */
// Purpose: byte-wide full-duplex serial port, master or slave
// Assumes: 125 MHz clock, async active-low nrst, all pins sampled via two flops
// Notes:   no register bus; control and status are plain ports
// Overview of operation
// - master drives serial clock out for each shifted bit
// - every transfer shifts one byte out and one byte in together
// - slave takes clock from pin, samples on rising edge, shifts on falling edge
// - bit-order bit chooses msb-first or lsb-first
// - idle-state bit sets data-out level after the byte
// - two-bit delay field delays data-out changes
// - master bit rate never exceeds 8 MHz; slave bit rate follows the external clock
// - read-full flag sets once eight bits are shifted
// - start loads transmit byte, begins shifting, reads one while busy
// - default order shifts msb first in and out
// - eighth bit copies byte to read buffer, sets full and done flags
// - reading the read buffer clears read-full
// - writes to the write buffer during a shift are refused
// - three-bit rate field picks shift clock rate in master mode
// - master mode bit picks internal or external shift clock
// - edge bit picks serial clock edge for data
// - data input ignored, high impedance, when not selected
// - only master uses rate and edge bits; slave latches on pin rising edge
// - edge and rate bits ignored in slave mode
// - select high: slave ignores data and releases data out
// - select-gated timing only in slave mode with select enabled
// - done event requests its own interrupt entry when enabled
// - flag sets regardless of mask; request is flag and mask
`timescale 1ns/1ps
`default_nettype none
`include "spims_map.vh"
module spims_port #(
   parameter RATE_W = 3
) (
   input  wire              clock,
   input  wire              nrst,
   input  wire              master_mode,
   input  wire              slave_select_en,
   input  wire              bit_order_select,
   input  wire              out_idle_state_ctl,
   input  wire              out_delay_sel_hi,
   input  wire              out_delay_sel_lo,
   input  wire              clock_edge_select,
   input  wire [RATE_W-1:0] rate_select,
   input  wire              xfer_done_irq_enable,
   input  wire [7:0]        tx_wdata,
   input  wire              tx_write,
   input  wire              shift_start_set,
   input  wire              rx_read,
   input  wire              irq_flag_clear,
   output reg  [7:0]        tx_holding_buffer,
   output reg  [7:0]        rx_holding_buffer,
   output reg               shift_start,
   output reg               read_full_flag,
   output reg               xfer_done_irq_flag,
   output wire              xfer_done_irq,
   output wire              tx_write_refused,
   input  wire              sck_in,
   output reg               sck_out,
   output reg               sck_oe,
   input  wire              sdi_in,
   output reg               sdo_out,
   output reg               sdo_oe,
   input  wire              ss_n_in
);
   // =====================================
   // pin synchronisers
   wire [2:0] pin_sync;
   spims_sync #(
      .W (3)
   ) u_sync (
      .clock (clock),
      .nrst  (nrst),
      .d     ({sck_in, sdi_in, ss_n_in}),
      .q     (pin_sync)
   );
   wire sck_s  = pin_sync[2];
   wire sdi_s  = pin_sync[1];
   wire ss_n_s = pin_sync[0];

   // =====================================
   // state machine
   localparam ST_IDLE  = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_DONE  = 3'b100;
   reg  [2:0] state_reg;
   reg  [2:0] state_next;
   reg  [7:0] shift_reg;
   reg  [3:0] bit_cnt_reg;
   reg [10:0] div_cnt_reg;
   reg        sck_prev_reg;
   reg        phase_reg;
   reg  [1:0] dly_cnt_reg;
   reg        sdo_pend_reg;
   reg        sdo_val_reg;

   // slave with select enabled sees the port only while select is low
   wire selected  = master_mode | ~slave_select_en | ~ss_n_s;
   wire busy      = state_reg == ST_SHIFT;

   // =====================================
   // internal rate: divide from the least legal half period upward
   // widened so the slowest rate (8 << 7) does not wrap to zero
   localparam [10:0] MIN_HALF = `SPIMS_MIN_HALF_CYC;
   wire [10:0] half_cyc = MIN_HALF << rate_select;
   wire        int_tick = master_mode && busy && (div_cnt_reg == half_cyc - 11'h001);

   // external clock edges; edge select only matters in master mode
   wire ext_rise  = sck_s & ~sck_prev_reg;
   wire ext_fall  = ~sck_s & sck_prev_reg;
   wire slv_edge  = ext_rise;
   wire slv_shift = ext_fall;
   // master: sample on leading half, shift on trailing half
   wire m_sample  = int_tick && (phase_reg == 1'b0);
   wire m_shift   = int_tick && (phase_reg == 1'b1);
   wire sample_ev = master_mode ? m_sample : (slv_edge & selected);
   wire shift_ev  = master_mode ? m_shift  : (slv_shift & selected);

   wire out_bit   = bit_order_select ? shift_reg[0] : shift_reg[7];
   wire [1:0] dly_sel = {out_delay_sel_hi, out_delay_sel_lo};

   // refusal follows the start bit, so the done cycle refuses as well
   assign tx_write_refused = tx_write & shift_start;
   assign xfer_done_irq    = xfer_done_irq_flag & xfer_done_irq_enable;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:  if (shift_start_set) state_next = ST_SHIFT;
         ST_SHIFT: if (bit_cnt_reg == 4'd`SPIMS_BITS) state_next = ST_DONE;
         ST_DONE:  state_next = ST_IDLE;
         default:  state_next = ST_IDLE;
      endcase
   end

   // =====================================
   // shifter and datapath
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg          <= ST_IDLE;
         shift_reg          <= `SPIMS_RESET_BYTE;
         bit_cnt_reg        <= 4'h0;
         div_cnt_reg        <= 11'h000;
         sck_prev_reg       <= 1'b0;
         phase_reg          <= 1'b0;
         tx_holding_buffer  <= `SPIMS_RESET_BYTE;
         rx_holding_buffer  <= `SPIMS_RESET_BYTE;
         shift_start        <= 1'b0;
         read_full_flag     <= 1'b0;
         xfer_done_irq_flag <= 1'b0;
         sck_out            <= 1'b0;
         sck_oe             <= 1'b0;
      end else begin
         state_reg    <= state_next;
         sck_prev_reg <= sck_s;
         if (tx_write && !shift_start)
            tx_holding_buffer <= tx_wdata;
         if (state_reg == ST_IDLE && shift_start_set) begin
            shift_reg   <= tx_holding_buffer;
            shift_start <= 1'b1;
            bit_cnt_reg <= 4'h0;
            div_cnt_reg <= 11'h000;
            phase_reg   <= 1'b0;
         end
         if (busy) begin
            div_cnt_reg <= int_tick ? 11'h000 : div_cnt_reg + 11'h001;
            if (int_tick)
               phase_reg <= ~phase_reg;
            if (sample_ev) begin
               // input bit lands opposite the outgoing end
               if (bit_order_select)
                  shift_reg <= {sdi_s, shift_reg[7:1]};
               else
                  shift_reg <= {shift_reg[6:0], sdi_s};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end
         // master clock pin: idle level set by edge bit
         sck_oe  <= master_mode;
         if (master_mode && busy && int_tick && bit_cnt_reg < 4'd`SPIMS_BITS)
            sck_out <= ~sck_out;
         else if (!busy)
            sck_out <= clock_edge_select;
         if (state_reg == ST_DONE) begin
            rx_holding_buffer  <= shift_reg;
            shift_start        <= 1'b0;
         end
         // set beats clear for both flags
         if (state_reg == ST_DONE)
            read_full_flag <= 1'b1;
         else if (rx_read)
            read_full_flag <= 1'b0;
         if (state_reg == ST_DONE)
            xfer_done_irq_flag <= 1'b1;
         else if (irq_flag_clear)
            xfer_done_irq_flag <= 1'b0;
      end
   end

   // =====================================
   // data-out with programmable delay
   // delay counts system clocks; long settings trade setup margin for hold
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dly_cnt_reg  <= 2'b00;
         sdo_pend_reg <= 1'b0;
         sdo_val_reg  <= 1'b0;
         sdo_out      <= 1'b0;
         sdo_oe       <= 1'b0;
      end else begin
         sdo_oe <= selected;
         if (busy && (shift_ev || bit_cnt_reg == 4'h0) && !sdo_pend_reg) begin
            sdo_pend_reg <= 1'b1;
            sdo_val_reg  <= out_bit;
            dly_cnt_reg  <= dly_sel;
         end else if (sdo_pend_reg) begin
            if (dly_cnt_reg == 2'b00) begin
               sdo_out      <= sdo_val_reg;
               sdo_pend_reg <= 1'b0;
            end else
               dly_cnt_reg <= dly_cnt_reg - 2'b01;
         end else if (state_reg == ST_DONE)
            sdo_out <= out_idle_state_ctl;
      end
   end
endmodule
`default_nettype wire

/* spims_port_props.sv */
// Purpose: assertions on the serial port
// Assumes: bound to spims_port
// Notes:   pin timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module spims_port_props (
   input wire logic clock,
   input wire logic nrst,
   input wire logic master_mode,
   input wire logic slave_select_en,
   input wire logic ss_n_in,
   input wire logic sck_oe,
   input wire logic sdo_oe,
   input wire logic tx_write,
   input wire logic shift_start_set,
   input wire logic rx_read,
   input wire logic irq_flag_clear,
   input wire logic shift_start,
   input wire logic xfer_done_irq_enable,
   input wire logic xfer_done_irq_flag,
   input wire logic xfer_done_irq,
   input wire logic read_full_flag,
   input wire logic tx_write_refused
);
   // ====
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   refuse_busy_a: assert property (
      tx_write_refused == (tx_write && shift_start)) else $error("bad refusal");
   start_take_a: assert property (
      shift_start_set && !shift_start |=> shift_start) else $error("start lost");
   irq_gate_a: assert property (
      xfer_done_irq == (xfer_done_irq_flag && xfer_done_irq_enable)) else $error("bad irq");
   done_flags_a: assert property (
      $fell(shift_start) && $past(nrst) |-> ##[0:1] (read_full_flag && xfer_done_irq_flag))
      else $error("flags missing");
   // set wins over clear, so only reads clear of a completion
   read_clr_a: assert property (
      rx_read && !shift_start && !$past(shift_start) |=> !read_full_flag)
      else $error("full kept");
   flag_clr_a: assert property (
      irq_flag_clear && !shift_start && !$past(shift_start) |=> !xfer_done_irq_flag)
      else $error("irq flag kept");
   slave_sck_a: assert property (
      !master_mode && !$past(master_mode) |-> !sck_oe) else $error("slave drives clock");
   // select passes two sync flops and a register
   sdo_float_a: assert property (
      (!master_mode && slave_select_en && ss_n_in)[*4] |-> !sdo_oe) else $error("sdo driven");
endmodule
bind spims_port spims_port_props spims_port_props_inst (.*);
`default_nettype wire

/* spims_peer.sv */
// Purpose: far-side serial device, slave or master
// Assumes: bench calls load or drive
// Notes:   msb first; released data line shows the inverse bit
`timescale 1ns/1ps
`default_nettype none
module spims_peer (
   input  wire logic       sck_out,
   input  wire logic       sdo_out,
   output logic            sdi_in,
   output logic            sck_in,
   output logic            ss_n_in,
   output logic [7:0]      peer_rx
);
   logic [7:0] sh = 8'h00;
   logic       act = 1'b0;
   logic       idle = 1'b0;
   initial {sdi_in, sck_in, ss_n_in, peer_rx} = {3'h1, 8'h00};
   // ====
   // slave role: take on leading edge, shift on trailing
   task automatic load(input logic [7:0] b, input logic i);
      {sh, idle, sdi_in, act} = {b, i, b[7], 1'b1};
   endtask
   always @(sck_out) if (act) begin
      if (sck_out !== idle) peer_rx = {peer_rx[6:0], sdo_out};
      else {sh, sdi_in} = {sh[6:0], ~sh[7], sh[6]};
   end
   // ====
   // master role: link clock runs only inside the frame
   task automatic drive(input logic [7:0] b);
      {sh, act, ss_n_in, sdi_in} = {b, 2'h0, b[7]};
      #96;
      repeat (8) begin
         #32 sck_in = 1'b1;
         // sample late: slave data moves well after the falling edge
         #32 peer_rx = {peer_rx[6:0], sdo_out};
         {sck_in, sh, sdi_in} = {1'b0, sh[6:0], ~sh[7], sh[6]};
      end
      #96 ss_n_in = 1'b1;
      sdi_in = ~sdi_in;
   endtask
endmodule
`default_nettype wire

/* spims_port_tb.sv */
// Purpose: self-checking bench for the serial port
// Assumes: peer model on the pins, 125 MHz clock
// Notes:   sdo delay kept at zero in slave runs, link half period is short
`timescale 1ns/1ps
`default_nettype none
module spims_port_tb;
   logic       clock, nrst, master_mode, slave_select_en, bit_order_select;
   logic       out_idle_state_ctl, out_delay_sel_hi, out_delay_sel_lo, clock_edge_select;
   logic       xfer_done_irq_enable, tx_write, shift_start_set, rx_read, irq_flag_clear;
   logic       shift_start, read_full_flag, xfer_done_irq_flag, xfer_done_irq;
   logic       tx_write_refused, sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe, ss_n_in;
   logic [2:0] rate_select;
   logic [7:0] tx_wdata, tx_holding_buffer, rx_holding_buffer, peer_rx;
   int         num_errors = 0, checks_done = 0, cycles = 0, n;
   spims_port spims_port_inst (.*);
   spims_peer spims_peer_inst (.*);
   // ====
   // clock, timeout, reporting
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         final_report;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one-cycle pulses: write, start, read, flag clear
   task automatic req(input logic [3:0] f, input logic [7:0] d);
      @(posedge clock);
      {tx_write, shift_start_set, rx_read, irq_flag_clear, tx_wdata} <= {f, d};
      @(posedge clock);
      {tx_write, shift_start_set, rx_read, irq_flag_clear} <= 4'h0;
      #1;
   endtask
   task automatic wait_idle;
      for (n = 0; shift_start !== 1'b0 && n < 3000; n++) @(posedge clock);
      repeat (4) @(posedge clock);
      #1;
   endtask
   // ====
   // scenarios
   task automatic t_master(input logic o, input logic [7:0] tx, ptx, erx, epeer);
      @(posedge clock);
      {master_mode, bit_order_select, out_idle_state_ctl, clock_edge_select} <= {1'b1, {3{o}}};
      {out_delay_sel_hi, out_delay_sel_lo, xfer_done_irq_enable, rate_select} <= {{3{o}}, 2'h0, o};
      repeat (4) @(posedge clock);
      spims_peer_inst.load(ptx, o);
      req(4'h8, tx);
      chk("tx buffer", tx, tx_holding_buffer);
      req(4'h4, 8'h00);
      req(4'h8, ~tx);
      chk("busy write", tx, tx_holding_buffer);
      chk("busy start", 8'h01, shift_start);
      chk("clock oe", 8'h01, sck_oe);
      wait_idle;
      chk("rx buffer", erx, rx_holding_buffer);
      chk("peer byte", epeer, peer_rx);
      chk("full flag", 8'h01, read_full_flag);
      chk("irq out", o, xfer_done_irq);
      chk("idle data", o, sdo_out);
      chk("start clear", 8'h00, shift_start);
      req(4'h3, 8'h00);
      chk("full clear", 8'h00, read_full_flag);
      chk("irq clear", 8'h00, xfer_done_irq_flag);
   endtask
   // edge and rate set to odd values: slave must ignore them
   task automatic t_slave(input logic [7:0] tx, ptx);
      @(posedge clock);
      {master_mode, slave_select_en, bit_order_select, clock_edge_select} <= 4'h5;
      {out_delay_sel_hi, out_delay_sel_lo, rate_select} <= 5'h07;
      req(4'h8, tx);
      req(4'h4, 8'h00);
      spims_peer_inst.drive(ptx);
      wait_idle;
      chk("slave rx", ptx, rx_holding_buffer);
      chk("slave tx", tx, peer_rx);
      chk("slave sdo oe", 8'h00, sdo_oe);
      chk("slave sck oe", 8'h00, sck_oe);
      req(4'h3, 8'h00);
   endtask
   initial begin
      {master_mode, slave_select_en, bit_order_select, out_idle_state_ctl} = 4'h0;
      {out_delay_sel_hi, out_delay_sel_lo, clock_edge_select} = 3'h0;
      {xfer_done_irq_enable, rate_select} = 4'h0;
      {tx_write, shift_start_set, rx_read, irq_flag_clear, tx_wdata} = 12'h000;
      nrst = 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      t_master(1'b0, 8'ha5, 8'h3c, 8'h3c, 8'ha5);
      t_master(1'b1, 8'h1e, 8'h6c, 8'h36, 8'h78);
      t_slave(8'hc3, 8'h5a);
      final_report;
   end
endmodule
`default_nettype wire
